// file: rtl/sdm_map.svh
// Constants for the serial port direction and route controller.
// Assumes inclusion by rtl/sdm_pkg.sv and rtl/sdm_ctrl.sv.
`ifndef SDM_MAP_SVH
`define SDM_MAP_SVH
// Strap thresholds in thousandths of the supply, sampled as 10-bit codes
`define SDM_ADC_W 10
`define SDM_ADC_FULL 1023
`define SDM_THR_LR_MILLI 200
`define SDM_THR_RF_MILLI 500
`define SDM_THR_FH_MILLI 800
`define SDM_MILLI 1000
// Strap must hold this many cycles before acting
`define SDM_STABLE_CYC 8
`define SDM_STABLE_W 4
// Clock-recovery reset pulse length in ns, clock period in ns
`define SDM_CDR_RST_NS 400
`define SDM_CLK_NS 40
`define SDM_CDR_CNT_W 8
// Management bus ready time after power-up in ms
`define SDM_MGMT_READY_MS 50
`define SDM_MGMT_CNT_W 21
// Clock cycles in one millisecond
`define SDM_CYC_PER_MS 25000
// Reset values
`define SDM_DIR_RST 1'b0
`endif

// file: rtl/sdm_pkg.sv
// Types for the serial port direction and route controller.
// Assumes nothing of its surroundings.
`include "sdm_map.svh"
package sdm_pkg;
  typedef enum logic [1:0] {
    SDM_LVL_L,
    SDM_LVL_R,
    SDM_LVL_F,
    SDM_LVL_H
  } sdm_level_t;
  typedef enum logic [1:0] {
    SDM_ST_RUN,
    SDM_ST_CDR_RST,
    SDM_ST_RELOCK
  } sdm_state_t;
endpackage

// file: rtl/sdm_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module sdm_buf2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_data
);
  logic [1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// file: rtl/sdm_ctrl.sv
// Direction and route controller for a bidirectional serial video port.
// Assumes strap levels arrive as sampled 10-bit codes from pin converters,
// asynchronous to clk; data words arrive on clk with valid/ready.
`timescale 1ns/1ns
`default_nettype none
`include "sdm_map.svh"
module sdm_ctrl
  import sdm_pkg::*;
#(
  parameter int unsigned MGMT_READY_CYC = `SDM_MGMT_READY_MS * `SDM_CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] direction_select_code,
  input wire logic [9:0] host_output_select_code,
  input wire logic [9:0] secondary_driver_select_code,
  input wire logic cdr_locked,
  input wire logic line_in_valid,
  output logic line_in_ready,
  input wire logic [1:0] line_in_data,
  input wire logic host_in_valid,
  output logic host_in_ready,
  input wire logic [1:0] host_in_data,
  output logic line_out_valid,
  input wire logic line_out_ready,
  output logic [1:0] line_out_data,
  output logic sec_out_valid,
  input wire logic sec_out_ready,
  output logic [1:0] sec_out_data,
  output logic host_out_valid,
  input wire logic host_out_ready,
  output logic [1:0] host_out_data,
  output logic equalizer_en,
  output logic cable_driver_en,
  output logic host_eq_en,
  output logic secondary_coax_driver_en,
  output logic host_diff_output_en,
  output logic cdr_reset,
  output logic lock,
  output logic mgmt_ready,
  output logic [1:0] direction_level,
  output logic [1:0] host_output_level,
  output logic [1:0] secondary_driver_level
);
  localparam logic [`SDM_ADC_W-1:0] THR_LR =
    `SDM_ADC_W'((`SDM_ADC_FULL * `SDM_THR_LR_MILLI) / `SDM_MILLI);
  localparam logic [`SDM_ADC_W-1:0] THR_RF =
    `SDM_ADC_W'((`SDM_ADC_FULL * `SDM_THR_RF_MILLI) / `SDM_MILLI);
  localparam logic [`SDM_ADC_W-1:0] THR_FH =
    `SDM_ADC_W'((`SDM_ADC_FULL * `SDM_THR_FH_MILLI) / `SDM_MILLI);
  localparam int unsigned CDR_RST_CYC =
    (`SDM_CDR_RST_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS;

  //////////////////////////////////////////////////////////////////////////
  // Strap synchronisers and four-level decode
  logic [9:0] code_s1_q [3];
  logic [9:0] code_s2_q [3];
  logic [1:0] lvl [3];
  logic [1:0] lvl_q [3];
  logic [9:0] code_in [3];

  assign code_in[0] = direction_select_code;
  assign code_in[1] = host_output_select_code;
  assign code_in[2] = secondary_driver_select_code;

  for (genvar i = 0; i < 3; i++) begin : g_strap
    // Not reset, so the strap level is settled when reset releases
    always_ff @(posedge clk) begin
      code_s1_q[i] <= code_in[i];
      code_s2_q[i] <= code_s1_q[i];
    end
    always_comb begin
      // Open pin biases to 2/3 supply, between RF and FH
      if (code_s2_q[i] < THR_LR) begin
        lvl[i] = SDM_LVL_L;
      end else if (code_s2_q[i] < THR_RF) begin
        lvl[i] = SDM_LVL_R;
      end else if (code_s2_q[i] < THR_FH) begin
        lvl[i] = SDM_LVL_F;
      end else begin
        lvl[i] = SDM_LVL_H;
      end
    end
    // Decoded levels leave the block from flip-flops
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        lvl_q[i] <= SDM_LVL_F;
      end else begin
        lvl_q[i] <= lvl[i];
      end
    end
  end

  assign direction_level = lvl_q[0];
  assign host_output_level = lvl_q[1];
  assign secondary_driver_level = lvl_q[2];

  // High is H or F; low is L or R
  logic dir_raw;
  logic hsel_raw;
  logic ssel_raw;
  assign dir_raw = lvl[0][1];
  assign hsel_raw = lvl[1][1];
  assign ssel_raw = lvl[2][1];

  //////////////////////////////////////////////////////////////////////////
  // Stability filter for the direction strap
  logic dir_q;
  logic [`SDM_STABLE_W-1:0] stab_q;
  logic dir_change;

  assign dir_change = (stab_q == `SDM_STABLE_W'(`SDM_STABLE_CYC - 1)) &&
    (dir_raw != dir_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stab_q <= '0;
    end else if (dir_raw == dir_q) begin
      stab_q <= '0;
    end else if (stab_q != `SDM_STABLE_W'(`SDM_STABLE_CYC - 1)) begin
      stab_q <= stab_q + `SDM_STABLE_W'(1);
    end else begin
      stab_q <= '0;
    end
  end

  // Power-up strap capture after release, then filtered changes
  logic started_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_q <= `SDM_DIR_RST;
      started_q <= 1'b0;
    end else if (!started_q) begin
      started_q <= 1'b1;
      dir_q <= dir_raw;
    end else if (dir_change) begin
      dir_q <= dir_raw;
    end
  end

  // Route selects follow straps after synchronisation
  logic hsel_q;
  logic ssel_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hsel_q <= 1'b1;
      ssel_q <= 1'b1;
    end else begin
      hsel_q <= hsel_raw;
      ssel_q <= ssel_raw;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock-recovery reset sequencer
  sdm_state_t st_q;
  logic [`SDM_CDR_CNT_W-1:0] cdr_cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= SDM_ST_CDR_RST;
      cdr_cnt_q <= '0;
    end else begin
      case (st_q)
        SDM_ST_RUN: begin
          if (dir_change && started_q) begin
            st_q <= SDM_ST_CDR_RST;
            cdr_cnt_q <= '0;
          end
        end
        SDM_ST_CDR_RST: begin
          if (cdr_cnt_q == `SDM_CDR_CNT_W'(CDR_RST_CYC - 1)) begin
            st_q <= SDM_ST_RELOCK;
          end else begin
            cdr_cnt_q <= cdr_cnt_q + `SDM_CDR_CNT_W'(1);
          end
        end
        SDM_ST_RELOCK: begin
          if (dir_change) begin
            st_q <= SDM_ST_CDR_RST;
            cdr_cnt_q <= '0;
          end else if (cdr_locked) begin
            st_q <= SDM_ST_RUN;
          end
        end
        default: st_q <= SDM_ST_CDR_RST;
      endcase
    end
  end

  assign cdr_reset = (st_q == SDM_ST_CDR_RST);
  assign lock = (st_q == SDM_ST_RUN) && cdr_locked;

  //////////////////////////////////////////////////////////////////////////
  // Path enables
  logic path_ok;
  assign path_ok = (st_q != SDM_ST_CDR_RST);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      equalizer_en <= 1'b0;
      cable_driver_en <= 1'b0;
      host_eq_en <= 1'b0;
      secondary_coax_driver_en <= 1'b0;
      host_diff_output_en <= 1'b0;
    end else begin
      equalizer_en <= ~dir_q;
      cable_driver_en <= dir_q;
      host_eq_en <= dir_q;
      secondary_coax_driver_en <= ~ssel_q;
      host_diff_output_en <= ~dir_q || ~hsel_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Data routing through a two-entry buffer
  logic src_valid;
  logic [1:0] src_data;
  logic buf_in_ready;
  logic buf_valid;
  logic [1:0] buf_data;
  logic need_main;
  logic need_sec;
  logic need_host;
  logic sink_ready;
  logic buf_rst_n;

  // Words of the old direction are dropped by a recovery reset
  assign buf_rst_n = rst_n && path_ok;
  assign src_valid = path_ok && (dir_q ? host_in_valid : line_in_valid);
  assign src_data = dir_q ? host_in_data : line_in_data;
  assign line_in_ready = path_ok && ~dir_q && buf_in_ready;
  assign host_in_ready = path_ok && dir_q && buf_in_ready;

  sdm_buf2 u_buf (
    .clk(clk),
    .rst_n(buf_rst_n),
    .in_valid(src_valid),
    .in_ready(buf_in_ready),
    .in_data(src_data),
    .out_valid(buf_valid),
    .out_ready(sink_ready),
    .out_data(buf_data)
  );

  assign need_main = dir_q;
  assign need_sec = ~ssel_q;
  assign need_host = ~dir_q || ~hsel_q;
  // Broadcast: a word leaves only when every enabled sink takes it
  assign sink_ready = path_ok && (~need_main || line_out_ready) &&
    (~need_sec || sec_out_ready) && (~need_host || host_out_ready);

  assign line_out_valid = buf_valid && need_main && sink_ready;
  assign sec_out_valid = buf_valid && need_sec && sink_ready;
  assign host_out_valid = buf_valid && need_host && sink_ready;

  // Data lags the handshake by one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_out_data <= 2'h0;
      sec_out_data <= 2'h0;
      host_out_data <= 2'h0;
    end else begin
      line_out_data <= buf_data;
      sec_out_data <= buf_data;
      host_out_data <= buf_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Management bus ready timer
  // Counts once after reset, then holds ready high
  logic [`SDM_MGMT_CNT_W-1:0] mgmt_cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mgmt_cnt_q <= '0;
      mgmt_ready <= 1'b0;
    end else if (mgmt_cnt_q == `SDM_MGMT_CNT_W'(MGMT_READY_CYC - 1)) begin
      mgmt_ready <= 1'b1;
    end else begin
      mgmt_cnt_q <= mgmt_cnt_q + `SDM_MGMT_CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// file: verif/sdm_ctrl_monitor.sv
// Checker on the controller's top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module sdm_ctrl_monitor #(
  parameter int unsigned MGMT_READY_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cdr_locked,
  input wire logic line_in_ready,
  input wire logic host_in_ready,
  input wire logic equalizer_en,
  input wire logic cable_driver_en,
  input wire logic host_eq_en,
  input wire logic host_diff_output_en,
  input wire logic cdr_reset,
  input wire logic lock,
  input wire logic mgmt_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] up_q;
  // Cycles since reset release, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_q <= 8'h00;
    end else if (up_q != 8'hFF) begin
      up_q <= up_q + 8'h01;
    end
  end
  chk_one_path: assert property (!(equalizer_en && cable_driver_en))
    else $error("both coax directions enabled");
  chk_eq_routes: assert property (equalizer_en |-> host_diff_output_en && !host_eq_en)
    else $error("equalizer direction routes wrong");
  chk_cd_routes: assert property (cable_driver_en |-> host_eq_en)
    else $error("host equalizer off in driver direction");
  chk_cdr_len: assert property ($rose(cdr_reset) |->
      cdr_reset [*8] ##1 cdr_reset ##1 cdr_reset ##1 !cdr_reset)
    else $error("recovery reset not ten cycles");
  chk_flip_reset: assert property ($changed(cable_driver_en) |-> cdr_reset)
    else $error("direction change without recovery reset");
  chk_lock_cause: assert property (lock |-> cdr_locked && !cdr_reset)
    else $error("lock shown without relock");
  chk_in_refused: assert property (cdr_reset |-> !line_in_ready && !host_in_ready)
    else $error("input taken during recovery reset");
  chk_mgmt_early: assert property (up_q < MGMT_READY_CYC - 1 |-> !mgmt_ready)
    else $error("management ready too early");
  chk_mgmt_late: assert property (up_q > MGMT_READY_CYC + 1 |-> mgmt_ready)
    else $error("management ready too late");
endmodule
bind sdm_ctrl sdm_ctrl_monitor #(.MGMT_READY_CYC(MGMT_READY_CYC)) mon (.*);
`default_nettype wire

// file: verif/sdm_far_model.sv
// Far side: recovery loop lock, output sinks with prompt or slow ready.
// Assumes one clock; streams packed {host, sec, line}.
`timescale 1ns/1ns
`default_nettype none
module sdm_far_model #(
  parameter int LOCK_CYC = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic cdr_reset,
  output logic cdr_locked,
  output logic ready,
  input wire logic [2:0] valid,
  input wire logic [5:0] data,
  output logic [5:0] last
);
  logic [3:0] lk_q;
  logic [2:0] hs_q;
  logic ph_q;
  always_ff @(posedge clk) begin
    if (!rst_n || cdr_reset) begin
      lk_q <= 4'h0;
    end else if (lk_q != LOCK_CYC[3:0]) begin
      lk_q <= lk_q + 4'h1;
    end
  end
  assign cdr_locked = (lk_q == LOCK_CYC[3:0]);
  always_ff @(posedge clk) begin
    ph_q <= rst_n && !ph_q;
  end
  assign ready = !slow || ph_q;
  // Word shows on data the cycle after the handshake
  always_ff @(posedge clk) begin
    hs_q <= valid & {3{ready}};
    if (!rst_n) begin
      last <= 6'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (hs_q[i]) begin
          last[2*i +: 2] <= data[2*i +: 2];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/sdm_ctrl_test.sv
// Testbench for the direction and route controller.
// Assumes the far side model and the port checker beside it.
`timescale 1ns/1ns
`default_nettype none
module sdm_ctrl_test;
  import sdm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, line_in_valid = 1'b0, host_in_valid = 1'b0;
  logic [9:0] direction_select_code = 10'h000, secondary_driver_select_code = 10'h000;
  logic [9:0] host_output_select_code = 10'h2AA;
  logic [1:0] line_in_data = 2'h0, host_in_data = 2'h0, line_out_data, sec_out_data;
  logic [1:0] host_out_data, direction_level, host_output_level, secondary_driver_level;
  logic cdr_locked, line_in_ready, host_in_ready, line_out_valid, sec_out_valid;
  logic host_out_valid, line_out_ready, sec_out_ready, host_out_ready, equalizer_en;
  logic cable_driver_en, host_eq_en, secondary_coax_driver_en, host_diff_output_en;
  logic cdr_reset, lock, mgmt_ready;
  logic [5:0] last;
  int n_errors = 0, n_tests = 0, hi;
  sdm_ctrl #(.MGMT_READY_CYC(20)) dut (.*);
  sdm_far_model far (.clk, .rst_n, .slow, .cdr_reset, .cdr_locked, .ready(line_out_ready),
    .valid({host_out_valid, sec_out_valid, line_out_valid}),
    .data({host_out_data, sec_out_data, line_out_data}), .last);
  assign sec_out_ready = line_out_ready;
  assign host_out_ready = line_out_ready;
  always #20 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic send(input logic host, input logic [1:0] w);
    int k;
    k = 0;
    @(posedge clk);
    if (host) begin
      host_in_valid <= 1'b1;
      host_in_data <= w;
    end else begin
      line_in_valid <= 1'b1;
      line_in_data <= w;
    end
    do @(negedge clk); while ((host ? host_in_ready : line_in_ready) !== 1'b1 && ++k < 200);
    @(posedge clk);
    host_in_valid <= 1'b0;
    line_in_valid <= 1'b0;
    if (k >= 200) n_errors++;
    repeat (10) @(posedge clk);
  endtask
  task automatic flip_wait(input string what, input int exp);
    hi = 0;
    repeat (40) begin
      @(negedge clk);
      hi += int'(cdr_reset);
    end
    chk(what, 8'(exp), 8'(hi));
    repeat (20) @(negedge clk);
    chk("lock", 8'd1, 8'(lock));
  endtask
  task automatic routes(input logic [4:0] exp);
    @(negedge clk);
    chk("enables", 8'(exp), 8'({equalizer_en, cable_driver_en, host_eq_en,
      host_diff_output_en, secondary_coax_driver_en}));
  endtask
  task automatic final_report;
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    // Straps set before reset release
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    flip_wait("cdr_rst", 10);
    chk("mgmt", 8'd1, 8'(mgmt_ready));
    chk("dir_lvl", 8'd0, 8'(direction_level));
    chk("host_lvl", 8'd2, 8'(host_output_level));
    routes(5'b10011);
    send(1'b0, 2'h2);
    chk("eq_word", 8'h28, 8'(last));
    @(posedge clk) direction_select_code <= 10'h3FF;
    repeat (4) @(posedge clk);
    direction_select_code <= 10'h000;
    flip_wait("glitch", 0);
    @(posedge clk) direction_select_code <= 10'h3FF;
    host_output_select_code <= 10'h000;
    flip_wait("cdr_len", 10);
    routes(5'b01111);
    send(1'b1, 2'h1);
    chk("cd_word", 8'h15, 8'(last));
    @(posedge clk) host_output_select_code <= 10'h3FF;
    secondary_driver_select_code <= 10'h3FF;
    slow <= 1'b1;
    routes(5'b01111);
    repeat (16) @(posedge clk);
    routes(5'b01100);
    send(1'b1, 2'h2);
    send(1'b1, 2'h3);
    chk("gated_word", 8'h17, 8'(last));
    @(posedge clk) direction_select_code <= 10'h000;
    slow <= 1'b0;
    flip_wait("back_len", 10);
    routes(5'b10010);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) secondary_driver_select_code <= 10'(i * 341);
      repeat (6) @(posedge clk);
      chk("sec_lvl", 8'(i), 8'(secondary_driver_level));
    end
    final_report();
  end
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
